// ### logic/prdc_cfg.svh
// Purpose: constants for the partial reload delivery checker
// Assumes: 32-bit apb data, 250 MHz pclk
// Notes:   offsets are byte addresses of aligned words
`ifndef PRDC_CFG_SVH
`define PRDC_CFG_SVH

`define PRDC_CLK_NS        4
`define PRDC_RESEED_NS     2000
`define PRDC_RESEED_CYC    ((`PRDC_RESEED_NS + `PRDC_CLK_NS - 1) / `PRDC_CLK_NS)

// stream framing; sync value is arbitrary
`define PRDC_SYNC_WORD     32'h5A5A_C3C3
`define PRDC_CRC_POLY      32'h04C1_1DB7
`define PRDC_CRC_INIT      32'hFFFF_FFFF
`define PRDC_FRAME_WORDS   16
`define PRDC_FRAME_LAST    4'hF

// register offsets
`define PRDC_OFS_CTRL      12'h000
`define PRDC_OFS_KEY       12'h004
`define PRDC_OFS_STATUS    12'h008
`define PRDC_OFS_PSTAT     12'h00C
`define PRDC_OFS_GEOM      12'h010

// ctrl fields
`define PRDC_CTRL_PFC      0
`define PRDC_CTRL_POST     1
`define PRDC_CTRL_IENC     2
`define PRDC_CTRL_RBL_LO   3
`define PRDC_CTRL_RBL_HI   4
`define PRDC_CTRL_NEWFAM   5
`define PRDC_CTRL_RESET    6'h00
`define PRDC_RBL_BLOCK     2'h2

// status fields
`define PRDC_ST_FULLREQ    4
`define PRDC_PSTAT_RSVD    4'hF

// smallest region heights, one column wide
`define PRDC_OLD_LOGIC_H   8'd50
`define PRDC_OLD_MULT_H    8'd10
`define PRDC_OLD_BRAM_H    8'd10
`define PRDC_NEW_LOGIC_H   8'd60
`define PRDC_NEW_MULT_H    8'd24
`define PRDC_NEW_BRAM_H    8'd12
`define PRDC_REGION_W      8'd1

`endif

// ### logic/prdc_crc.sv
// Purpose: one 32-bit crc step over a 32-bit word, msb first
// Assumes: used combinationally
// Notes:   none
`timescale 1ns/1ns
`include "prdc_cfg.svh"
module prdc_crc (
  // running value and word
  input  wire logic [31:0] crc_in,
  input  wire logic [31:0] data,
  // next value
  output      logic [31:0] crc_out
);

  function automatic logic [31:0] crc_step(input logic [31:0] c_in, input logic [31:0] d);
    logic [31:0] c;
    logic        fb;
    c  = c_in;
    fb = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      fb = c[31] ^ d[i];
      c  = {c[30:0], 1'b0};
      if (fb) begin
        c = c ^ `PRDC_CRC_POLY;
      end
    end
    return c;
  endfunction : crc_step

  assign crc_out = crc_step(crc_in, data);

endmodule : prdc_crc

// ### logic/prdc_pkg.sv
// Purpose: types shared by the partial reload delivery checker
// Assumes: nothing
// Notes:   opcodes sit in the top nibble of a command word
package prdc_pkg;

  typedef enum logic [2:0] {
    ST_UNSYNC = 3'b000,
    ST_CMD    = 3'b001,
    ST_FRAME  = 3'b010,
    ST_FCRC   = 3'b011,
    ST_COMMIT = 3'b100,
    ST_ECRC   = 3'b101
  } prdc_state_e;

  typedef enum logic [3:0] {
    OP_RESET_CRC = 4'h1,
    OP_FRAME     = 4'h2,
    OP_CHECK     = 4'h3,
    OP_ENC       = 4'h4,
    OP_DESYNC    = 4'h5
  } prdc_op_e;

endpackage : prdc_pkg

// ### logic/prdc_sem.sv
// Purpose: upset monitor reference recompute timer
// Assumes: start is a one-cycle pulse
// Notes:   a new start restarts the recompute
`timescale 1ns/1ns
`include "prdc_cfg.svh"
module prdc_sem (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control
  input  wire logic enable,
  input  wire logic start,
  // monitor state
  output      logic frame_valid_ff,
  output      logic busy_ff
);

  logic [15:0] cnt_ff;
  wire         done = busy_ff && (cnt_ff == 16'h0000);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff         <= 16'h0000;
      busy_ff        <= 1'b0;
      frame_valid_ff <= 1'b0;
    end else if (start && enable) begin
      cnt_ff  <= 16'(`PRDC_RESEED_CYC - 1);
      busy_ff <= 1'b1;
    end else if (done) begin
      busy_ff        <= 1'b0;
      frame_valid_ff <= ~frame_valid_ff;
    end else if (busy_ff) begin
      cnt_ff <= cnt_ff - 16'h0001;
    end
  end

endmodule : prdc_sem

// ### logic/prdc_top.sv
// Purpose: partial reload delivery checker with apb control and status
// Assumes: one word port shared by internal and external sources
// Notes:   frames are always buffered whole before they reach memory
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ns
`include "prdc_cfg.svh"
module prdc_top (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata_ff,
  output      logic        pready_ff,
  output      logic        pslverr_ff,
  // configuration word port
  input  wire logic        cfg_valid,
  input  wire logic [31:0] cfg_data,
  input  wire logic        cfg_src_external,
  output      logic        cfg_ready_ff,
  output      logic [31:0] cfg_status_ff,
  // configuration pins and flags
  input  wire logic        program_request_pin,
  output      logic        init_error_n_ff,
  output      logic        partial_reload_error_out_ff,
  output      logic        frame_valid_ff,
  // configuration memory write port
  output      logic        mem_we_ff,
  output      logic [23:0] mem_frame_addr_ff,
  output      logic [3:0]  mem_word_idx_ff,
  output      logic [31:0] mem_data_ff
);

  function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] ofs);
    return a == ofs;
  endfunction : reg_hit

  prdc_pkg::prdc_state_e state_ff;
  prdc_pkg::prdc_state_e nxt_state;
  logic [5:0]  ctrl_ff;
  logic [7:0]  key_ff;
  logic        full_req_ff;
  logic        err_ff;
  logic        crc_err_ff;
  logic        enc_rej_ff;
  logic        sec_rej_ff;
  logic        stream_enc_ff;
  logic        written_any_ff;
  logic [7:0]  frames_ff;
  logic [31:0] crc_ff;
  logic [31:0] fcrc_ff;
  logic [23:0] faddr_ff;
  logic [3:0]  widx_ff;
  logic [3:0]  ridx_ff;
  logic [31:0] fbuf_ff [`PRDC_FRAME_WORDS];
  logic        sem_busy;
  logic [31:0] crc_nxt;
  logic [31:0] fcrc_nxt;
  logic        crc_fail;
  logic        enc_rej;
  logic        sec_rej;
  logic        clr_err;
  logic        sem_start;

  // apb decode
  wire setup     = psel && !penable;
  wire wr_access = psel && penable && pwrite && pready_ff;
  wire hit_ctrl  = reg_hit(paddr, `PRDC_OFS_CTRL);
  wire hit_key   = reg_hit(paddr, `PRDC_OFS_KEY);
  wire hit_stat  = reg_hit(paddr, `PRDC_OFS_STATUS);
  wire hit_pstat = reg_hit(paddr, `PRDC_OFS_PSTAT);
  wire hit_geom  = reg_hit(paddr, `PRDC_OFS_GEOM);
  wire mapped    = hit_ctrl || hit_key || hit_stat || hit_pstat || hit_geom;

  // control fields
  wire       pfc_en   = ctrl_ff[`PRDC_CTRL_PFC];
  wire       post_en  = ctrl_ff[`PRDC_CTRL_POST];
  wire       init_enc = ctrl_ff[`PRDC_CTRL_IENC];
  wire [1:0] rb_level = ctrl_ff[`PRDC_CTRL_RBL_HI:`PRDC_CTRL_RBL_LO];
  wire       new_fam  = ctrl_ff[`PRDC_CTRL_NEWFAM];

  // word port decode; source only matters for security checks
  wire                   accept   = cfg_valid && cfg_ready_ff;
  wire prdc_pkg::prdc_op_e op     = prdc_pkg::prdc_op_e'(cfg_data[31:28]);
  wire                   is_sync  = cfg_data == `PRDC_SYNC_WORD;
  wire                   ext_lock = cfg_src_external && (rb_level >= `PRDC_RBL_BLOCK);
  wire                   key_ok   = cfg_data[7:0] == key_ff;
  wire                   sync_seen = state_ff != prdc_pkg::ST_UNSYNC;
  wire                   data_acc = accept && (state_ff == prdc_pkg::ST_FRAME);
  wire                   hdr_acc  = accept && (state_ff == prdc_pkg::ST_CMD) &&
                                    (op == prdc_pkg::OP_FRAME) && (nxt_state == prdc_pkg::ST_FRAME);
  wire                   crc_upd  = data_acc || (accept && (state_ff == prdc_pkg::ST_CMD) &&
                                    (op != prdc_pkg::OP_CHECK));
  wire                   commit_end = (state_ff == prdc_pkg::ST_COMMIT) &&
                                      (ridx_ff == `PRDC_FRAME_LAST);
  wire                   nxt_err  = (err_ff && !clr_err && !program_request_pin) ||
                                    crc_fail || enc_rej || sec_rej;

  // region geometry, read only
  wire [7:0]  geo_logic = new_fam ? `PRDC_NEW_LOGIC_H : `PRDC_OLD_LOGIC_H;
  wire [7:0]  geo_mult  = new_fam ? `PRDC_NEW_MULT_H : `PRDC_OLD_MULT_H;
  wire [7:0]  geo_bram  = new_fam ? `PRDC_NEW_BRAM_H : `PRDC_OLD_BRAM_H;
  wire [31:0] geom_word = {`PRDC_REGION_W, geo_bram, geo_mult, geo_logic};
  wire [31:0] stat_word = {16'h0000, frames_ff, 2'b00, sem_busy, full_req_ff,
                           sec_rej_ff, enc_rej_ff, sync_seen, crc_err_ff};
  wire [31:0] rd_mux    = hit_ctrl  ? {26'h000_0000, ctrl_ff} :
                          hit_key   ? {24'h00_0000, key_ff} :
                          hit_stat  ? stat_word :
                          hit_pstat ? cfg_status_ff :
                          hit_geom  ? geom_word : 32'h0000_0000;

  prdc_crc u_stream_crc (
    .crc_in  (crc_ff),
    .data    (cfg_data),
    .crc_out (crc_nxt)
  );

  prdc_crc u_frame_crc (
    .crc_in  (fcrc_ff),
    .data    (cfg_data),
    .crc_out (fcrc_nxt)
  );

  prdc_sem u_sem (
    .pclk           (pclk),
    .presetn        (presetn),
    .enable         (post_en),
    .start          (sem_start),
    .frame_valid_ff (frame_valid_ff),
    .busy_ff        (sem_busy)
  );

  always_comb begin
    nxt_state = state_ff;
    crc_fail  = 1'b0;
    enc_rej   = 1'b0;
    sec_rej   = 1'b0;
    clr_err   = 1'b0;
    sem_start = 1'b0;
    case (state_ff)
      prdc_pkg::ST_UNSYNC: begin
        if (accept && is_sync) begin
          if (ext_lock) begin
            sec_rej = 1'b1;
          end else begin
            nxt_state = prdc_pkg::ST_CMD;
          end
        end
      end
      prdc_pkg::ST_CMD: begin
        if (accept) begin
          case (op)
            prdc_pkg::OP_RESET_CRC: clr_err = 1'b1;
            prdc_pkg::OP_FRAME: begin
              if (init_enc && !stream_enc_ff && cfg_src_external) begin
                enc_rej   = 1'b1;
                nxt_state = prdc_pkg::ST_UNSYNC;
              end else begin
                nxt_state = prdc_pkg::ST_FRAME;
              end
            end
            prdc_pkg::OP_CHECK: nxt_state = prdc_pkg::ST_ECRC;
            prdc_pkg::OP_ENC: begin
              if (!init_enc || !key_ok) begin
                enc_rej   = 1'b1;
                nxt_state = prdc_pkg::ST_UNSYNC;
              end
            end
            prdc_pkg::OP_DESYNC: begin
              nxt_state = prdc_pkg::ST_UNSYNC;
              sem_start = written_any_ff;
            end
            default: nxt_state = prdc_pkg::ST_CMD;
          endcase
        end
      end
      prdc_pkg::ST_FRAME: begin
        if (accept && (widx_ff == `PRDC_FRAME_LAST)) begin
          nxt_state = prdc_pkg::ST_FCRC;
        end
      end
      prdc_pkg::ST_FCRC: begin
        if (accept) begin
          if (pfc_en && (cfg_data != fcrc_ff)) begin
            crc_fail  = 1'b1;
            nxt_state = prdc_pkg::ST_UNSYNC;
          end else begin
            nxt_state = prdc_pkg::ST_COMMIT;
          end
        end
      end
      prdc_pkg::ST_COMMIT: begin
        if (commit_end) begin
          nxt_state = prdc_pkg::ST_CMD;
        end
      end
      prdc_pkg::ST_ECRC: begin
        if (accept) begin
          crc_fail  = cfg_data != crc_ff;
          nxt_state = crc_fail ? prdc_pkg::ST_UNSYNC : prdc_pkg::ST_CMD;
        end
      end
      default: nxt_state = prdc_pkg::ST_UNSYNC;
    endcase
    if (program_request_pin) begin
      nxt_state = prdc_pkg::ST_UNSYNC;
    end
  end

  // apb slave, zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= 1'b1;
      if (setup) begin
        prdata_ff  <= rd_mux;
        pslverr_ff <= !mapped;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff     <= `PRDC_CTRL_RESET;
      key_ff      <= 8'h00;
      full_req_ff <= 1'b0;
    end else begin
      if (wr_access && hit_ctrl) ctrl_ff <= pwdata[5:0];
      if (wr_access && hit_key) key_ff <= pwdata[7:0];
      // pin assertion wins over a software clear in the same cycle
      full_req_ff <= program_request_pin ||
                     (full_req_ff && !(wr_access && hit_stat && pwdata[`PRDC_ST_FULLREQ]));
    end
  end

  // error latches and pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_ff                      <= 1'b0;
      crc_err_ff                  <= 1'b0;
      enc_rej_ff                  <= 1'b0;
      sec_rej_ff                  <= 1'b0;
      init_error_n_ff             <= 1'b1;
      partial_reload_error_out_ff <= 1'b0;
      cfg_status_ff               <= 32'h0000_0000;
    end else begin
      err_ff                      <= nxt_err;
      crc_err_ff                  <= crc_fail || (crc_err_ff && !clr_err);
      enc_rej_ff                  <= enc_rej || (enc_rej_ff && !clr_err);
      sec_rej_ff                  <= sec_rej || (sec_rej_ff && !clr_err);
      init_error_n_ff             <= !nxt_err;
      partial_reload_error_out_ff <= nxt_err;
      // sync bit lags the error by a cycle, so a failure shows once with sync still set
      cfg_status_ff <= {24'h00_0000, !nxt_err, sync_seen, 1'b0, 1'b1,
                        `PRDC_PSTAT_RSVD};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff      <= prdc_pkg::ST_UNSYNC;
      cfg_ready_ff  <= 1'b0;
      stream_enc_ff <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      cfg_ready_ff  <= nxt_state != prdc_pkg::ST_COMMIT;
      stream_enc_ff <= (nxt_state != prdc_pkg::ST_UNSYNC) && (stream_enc_ff ||
                       (accept && (state_ff == prdc_pkg::ST_CMD) &&
                        (op == prdc_pkg::OP_ENC) && init_enc && key_ok));
    end
  end

  // running and per-frame crc
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_ff  <= `PRDC_CRC_INIT;
      fcrc_ff <= `PRDC_CRC_INIT;
    end else begin
      if (clr_err || program_request_pin) crc_ff <= `PRDC_CRC_INIT;
      else if (crc_upd) crc_ff <= crc_nxt;
      if (hdr_acc) fcrc_ff <= `PRDC_CRC_INIT;
      else if (data_acc) fcrc_ff <= fcrc_nxt;
    end
  end

  // whole frame buffer; nothing reaches memory until the frame is complete
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `PRDC_FRAME_WORDS; i++) fbuf_ff[i] <= 32'h0000_0000;
      widx_ff  <= 4'h0;
      faddr_ff <= 24'h00_0000;
    end else if (hdr_acc) begin
      widx_ff  <= 4'h0;
      faddr_ff <= cfg_data[23:0];
    end else if (data_acc) begin
      fbuf_ff[widx_ff] <= cfg_data;
      widx_ff          <= widx_ff + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ridx_ff           <= 4'h0;
      mem_we_ff         <= 1'b0;
      mem_frame_addr_ff <= 24'h00_0000;
      mem_word_idx_ff   <= 4'h0;
      mem_data_ff       <= 32'h0000_0000;
    end else begin
      mem_we_ff <= state_ff == prdc_pkg::ST_COMMIT;
      if (state_ff == prdc_pkg::ST_COMMIT) begin
        mem_frame_addr_ff <= faddr_ff;
        mem_word_idx_ff   <= ridx_ff;
        mem_data_ff       <= fbuf_ff[ridx_ff];
        ridx_ff           <= ridx_ff + 4'h1;
      end else begin
        ridx_ff <= 4'h0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frames_ff      <= 8'h00;
      written_any_ff <= 1'b0;
    end else begin
      if (commit_end) frames_ff <= frames_ff + 8'h01;
      written_any_ff <= commit_end || (written_any_ff && !sem_start);
    end
  end

endmodule : prdc_top

// ### testbench/prdc_chk.sv
// Purpose: port assertions for the partial reload delivery checker
// Assumes: one pclk domain, presetn async active low
// Notes:   bound to prdc_top
`timescale 1ns/1ns
`include "prdc_cfg.svh"
module prdc_chk (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // word port
  input wire logic        cfg_valid,
  input wire logic [31:0] cfg_data,
  input wire logic        cfg_src_external,
  input wire logic        cfg_ready_ff,
  input wire logic [31:0] cfg_status_ff,
  // pins and memory port
  input wire logic        program_request_pin,
  input wire logic        init_error_n_ff,
  input wire logic        partial_reload_error_out_ff,
  input wire logic        frame_valid_ff,
  input wire logic        mem_we_ff,
  input wire logic [23:0] mem_frame_addr_ff,
  input wire logic [3:0]  mem_word_idx_ff
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire        take = cfg_valid & cfg_ready_ff;
  logic [9:0] quiet_ff;
  logic [9:0] nxt_quiet;
  // idle cycles on the word port; saturates so a long idle never wraps
  assign nxt_quiet = take ? 10'h000 : (quiet_ff == 10'h3FF) ? quiet_ff : quiet_ff + 10'h001;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) quiet_ff <= 10'h000;
    else quiet_ff <= nxt_quiet;
  end
  a_err_pair: assert property (partial_reload_error_out_ff == !init_error_n_ff)
    else $error("error output disagrees with init line");
  a_stat_err: assert property ($past(presetn) |-> cfg_status_ff[7] == init_error_n_ff)
    else $error("status bit 7 disagrees with init line");
  a_stat_fixed: assert property ($past(presetn) |->
    cfg_status_ff[5:0] == 6'h1F && cfg_status_ff[31:8] == 24'h00_0000)
    else $error("fixed status bits wrong");
  a_sync_seen: assert property (take && cfg_data == `PRDC_SYNC_WORD && !cfg_src_external
    && !cfg_status_ff[6] && !program_request_pin |=> ##[0:1] cfg_status_ff[6])
    else $error("sync word not reported");
  a_we_burst: assert property ($rose(mem_we_ff) |-> mem_word_idx_ff == 4'h0 ##15
    (mem_we_ff && mem_word_idx_ff == 4'hF) ##1 !mem_we_ff)
    else $error("frame write not sixteen words");
  a_we_step: assert property (mem_we_ff && $past(mem_we_ff) |->
    mem_word_idx_ff == $past(mem_word_idx_ff) + 4'h1 && $stable(mem_frame_addr_ff))
    else $error("frame word order broken");
  a_err_cause: assert property ($fell(init_error_n_ff) |-> $past(take) || $past(take, 2))
    else $error("error raised without a word");
  a_err_clear: assert property ($rose(init_error_n_ff) |-> $past(take) || $past(take, 2)
    || $past(program_request_pin) || $past(program_request_pin, 2))
    else $error("error released without a command");
  a_fv_wait: assert property ($changed(frame_valid_ff) |-> quiet_ff >= 10'h1E0)
    else $error("frame valid toggled before recompute");
endmodule : prdc_chk

bind prdc_top prdc_chk u_chk (
  .pclk(pclk), .presetn(presetn), .cfg_valid(cfg_valid), .cfg_data(cfg_data),
  .cfg_src_external(cfg_src_external), .cfg_ready_ff(cfg_ready_ff),
  .cfg_status_ff(cfg_status_ff), .program_request_pin(program_request_pin),
  .init_error_n_ff(init_error_n_ff),
  .partial_reload_error_out_ff(partial_reload_error_out_ff),
  .frame_valid_ff(frame_valid_ff), .mem_we_ff(mem_we_ff),
  .mem_frame_addr_ff(mem_frame_addr_ff), .mem_word_idx_ff(mem_word_idx_ff)
);

// ### testbench/prdc_src.sv
// Purpose: reconfiguration controller model feeding the word port
// Assumes: words change only after a rising edge
// Notes:   gap argument lets a word come late
`timescale 1ns/1ns
module prdc_src (
  // clock
  input  wire logic        pclk,
  // word port
  input  wire logic        cfg_ready_ff,
  output      logic        cfg_valid,
  output      logic [31:0] cfg_data,
  output      logic        cfg_src_external,
  // configuration pin
  output      logic        program_request_pin
);
  initial begin
    cfg_valid           = 1'b0;
    cfg_data            = 32'h0000_0000;
    cfg_src_external    = 1'b0;
    program_request_pin = 1'b0;
  end
  // one handshake for both sources
  task automatic put(input logic [31:0] w, input logic ext, input int gap);
    repeat (gap) @(posedge pclk);
    @(posedge pclk);
    cfg_valid        <= 1'b1;
    cfg_data         <= w;
    cfg_src_external <= ext;
    @(posedge pclk);
    while (cfg_ready_ff !== 1'b1) @(posedge pclk);
    cfg_valid <= 1'b0;
    // released bus shows the inverse so a stale word is never mistaken
    cfg_data  <= ~w;
  endtask : put
endmodule : prdc_src

// ### testbench/tb_partial_reconfig_delivery_check.sv
// Purpose: self-checking bench for the partial reload delivery checker
// Assumes: zero-wait apb, controller model on the word port
// Notes:   frame data words are A500_0000 plus index
`timescale 1ns/1ns
`include "prdc_cfg.svh"
module tb_partial_reconfig_delivery_check;
  logic        pclk, presetn, psel, penable, pwrite, pready_ff, pslverr_ff, err, fv;
  logic        cfg_valid, cfg_src_external, cfg_ready_ff, program_request_pin;
  logic        init_error_n_ff, partial_reload_error_out_ff, frame_valid_ff, mem_we_ff;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata_ff, cfg_data, cfg_status_ff, mem_data_ff, rd;
  logic [23:0] mem_frame_addr_ff, exp_addr;
  logic [3:0]  mem_word_idx_ff, exp_idx;
  int          n_mismatch, compares, n_we, k;
  localparam logic [31:0] w_sync = `PRDC_SYNC_WORD;
  localparam logic [31:0] w_clr  = {prdc_pkg::OP_RESET_CRC, 28'h000_0000};
  localparam logic [31:0] w_desy = {prdc_pkg::OP_DESYNC, 28'h000_0000};
  prdc_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_ff,
    .pready_ff, .pslverr_ff, .cfg_valid, .cfg_data, .cfg_src_external, .cfg_ready_ff,
    .cfg_status_ff, .program_request_pin, .init_error_n_ff, .partial_reload_error_out_ff,
    .frame_valid_ff, .mem_we_ff, .mem_frame_addr_ff, .mem_word_idx_ff, .mem_data_ff);
  prdc_src u_src (.pclk, .cfg_ready_ff, .cfg_valid, .cfg_data, .cfg_src_external,
    .program_request_pin);
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude;
    $display("mismatches=%0d compares=%0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready_ff !== 1'b1) @(posedge pclk);
    rd = prdata_ff;
    err = pslverr_ff;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic [31:0] crc(input logic [31:0] c, input logic [31:0] d);
    logic fb;
    for (int i = 31; i >= 0; i--) begin
      fb = c[31] ^ d[i];
      c = {c[30:0], 1'b0} ^ (fb ? `PRDC_CRC_POLY : 32'h0);
    end
    return c;
  endfunction : crc
  // waits out transients such as the one-cycle error-with-sync code
  task automatic st(input logic [7:0] e);
    for (k = 0; cfg_status_ff[7:0] !== e && k < 40; k++) @(posedge pclk);
    chk(cfg_status_ff, {24'h00_0000, e});
  endtask : st
  task automatic pins(input logic [1:0] e);
    chk({30'h0000_0000, init_error_n_ff, partial_reload_error_out_ff}, {30'h0000_0000, e});
  endtask : pins
  task automatic frame(input logic [23:0] a, input logic good, input logic ext);
    logic [31:0] c;
    c = `PRDC_CRC_INIT;
    exp_addr = a;
    n_we = 0;
    u_src.put({prdc_pkg::OP_FRAME, 4'h0, a}, ext, 0);
    for (int i = 0; i < `PRDC_FRAME_WORDS; i++) begin
      c = crc(c, 32'hA500_0000 + i);
      u_src.put(32'hA500_0000 + i, ext, i % 3);
    end
    u_src.put(good ? c : ~c, ext, 0);
  endtask : frame
  task automatic wait_we(input int n);
    for (k = 0; n_we < n && k < 60; k++) @(posedge pclk);
    repeat (2) @(posedge pclk);
    chk(n_we, n);
  endtask : wait_we
  task automatic recover(input logic ext);
    u_src.put(w_sync, ext, 0);
    u_src.put(w_clr, ext, 1);
    st(8'hDF);
    pins(2'h2);
  endtask : recover
  always @(posedge pclk) begin
    if (mem_we_ff === 1'b1) begin
      chk({8'h00, mem_frame_addr_ff}, {8'h00, exp_addr});
      chk({28'h000_0000, mem_word_idx_ff}, {28'h000_0000, exp_idx});
      chk(mem_data_ff, 32'hA500_0000 + exp_idx);
      exp_idx++;
      n_we++;
    end
  end
  task automatic t_regs;
    apb(1'b0, `PRDC_OFS_GEOM, 32'h0);
    chk(rd, 32'h010A_0A32);
    apb(1'b1, `PRDC_OFS_CTRL, 32'h20);
    apb(1'b1, `PRDC_OFS_GEOM, 32'hFFFF_FFFF);
    apb(1'b0, `PRDC_OFS_GEOM, 32'h0);
    chk(rd, 32'h010C_183C);
    apb(1'b0, 12'h040, 32'h0);
    chk({31'h0000_0000, err}, 32'h1);
    apb(1'b0, `PRDC_OFS_PSTAT, 32'h0);
    chk(rd, 32'h9F);
  endtask : t_regs
  task automatic t_good;
    apb(1'b1, `PRDC_OFS_CTRL, 32'h1);
    recover(1'b1);
    frame(24'h00_0100, 1'b1, 1'b1);
    wait_we(16);
    apb(1'b0, `PRDC_OFS_STATUS, 32'h0);
    chk(rd & 32'hFF01, 32'h0100);
  endtask : t_good
  task automatic t_bad;
    frame(24'h00_0200, 1'b0, 1'b0);
    st(8'h1F);
    pins(2'h1);
    wait_we(0);
    apb(1'b0, `PRDC_OFS_STATUS, 32'h0);
    chk(rd & 32'h1, 32'h1);
    recover(1'b0);
    frame(24'h00_0200, 1'b1, 1'b0);
    wait_we(16);
  endtask : t_bad
  task automatic t_plain;
    apb(1'b1, `PRDC_OFS_CTRL, 32'h0);
    frame(24'h00_0300, 1'b0, 1'b0);
    wait_we(16);
    st(8'hDF);
    u_src.put({prdc_pkg::OP_CHECK, 28'h000_0000}, 1'b0, 0);
    u_src.put(32'h0, 1'b0, 0);
    st(8'h1F);
    recover(1'b0);
    u_src.put(w_desy, 1'b0, 0);
    st(8'h9F);
  endtask : t_plain
  task automatic t_sec;
    apb(1'b1, `PRDC_OFS_CTRL, 32'h10);
    u_src.put(w_sync, 1'b1, 0);
    st(8'h1F);
    apb(1'b0, `PRDC_OFS_STATUS, 32'h0);
    chk(rd & 32'h8, 32'h8);
    recover(1'b0);
    u_src.put(w_desy, 1'b0, 0);
    apb(1'b1, `PRDC_OFS_CTRL, 32'h08);
    u_src.put(w_sync, 1'b1, 0);
    st(8'hDF);
  endtask : t_sec
  task automatic t_enc;
    apb(1'b1, `PRDC_OFS_KEY, 32'h3C);
    apb(1'b1, `PRDC_OFS_CTRL, 32'h05);
    u_src.put({prdc_pkg::OP_ENC, 20'h0_0000, 8'h5A}, 1'b0, 0);
    st(8'h1F);
    apb(1'b0, `PRDC_OFS_STATUS, 32'h0);
    chk(rd & 32'h4, 32'h4);
    recover(1'b0);
    frame(24'h00_0400, 1'b1, 1'b0);
    wait_we(16);
    u_src.put({prdc_pkg::OP_FRAME, 28'h000_0500}, 1'b1, 0);
    st(8'h1F);
    recover(1'b0);
    u_src.put({prdc_pkg::OP_ENC, 20'h0_0000, 8'h3C}, 1'b1, 0);
    frame(24'h00_0600, 1'b1, 1'b1);
    wait_we(16);
  endtask : t_enc
  task automatic t_post;
    // close the open session first: a sync word inside one decodes as desync
    u_src.put(w_desy, 1'b0, 0);
    apb(1'b1, `PRDC_OFS_CTRL, 32'h03);
    recover(1'b0);
    frame(24'h00_0700, 1'b1, 1'b0);
    wait_we(16);
    fv = frame_valid_ff;
    u_src.put(w_desy, 1'b0, 0);
    apb(1'b0, `PRDC_OFS_STATUS, 32'h0);
    chk(rd & 32'h20, 32'h20);
    for (k = 0; frame_valid_ff === fv && k < 700; k++) @(posedge pclk);
    chk({31'h0000_0000, frame_valid_ff !== fv && k > 480}, 32'h1);
  endtask : t_post
  task automatic t_full;
    recover(1'b0);
    @(posedge pclk);
    u_src.program_request_pin <= 1'b1;
    @(posedge pclk);
    u_src.program_request_pin <= 1'b0;
    st(8'h9F);
    apb(1'b0, `PRDC_OFS_STATUS, 32'h0);
    chk(rd & 32'h12, 32'h10);
    apb(1'b1, `PRDC_OFS_STATUS, 32'h10);
    apb(1'b0, `PRDC_OFS_STATUS, 32'h0);
    chk(rd & 32'h10, 32'h0);
  endtask : t_full
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {n_mismatch, compares, n_we, exp_idx, exp_addr} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    st(8'h9F);
    pins(2'h2);
    t_regs;
    t_good;
    t_bad;
    t_plain;
    t_sec;
    t_enc;
    t_post;
    t_full;
    conclude;
  end
  // generous bound: the whole sequence needs little more than a thousand cycles
  initial begin
    #100000;
    n_mismatch++;
    conclude;
  end
endmodule : tb_partial_reconfig_delivery_check
